// [core/clps_pkg.sv]
// Shared constants for the custom transmit pulse shape block.
package clps_pkg;

    // Width of the register address and page select.
    localparam int ADDR_W = 5;
    localparam int PAGE_W = 3;

    // Page that holds the pulse level registers.
    localparam logic [2:0] PAGE_PULSE = 3'h2;

    // Register offsets inside the page.
    localparam logic [4:0] OFS_SLOT_ONE   = 5'h1C;
    localparam logic [4:0] OFS_SLOT_TWO   = 5'h1D;
    localparam logic [4:0] OFS_SLOT_THREE = 5'h1E;
    localparam logic [4:0] OFS_SLOT_FOUR  = 5'h1F;

    // Field layout of a pulse level register.
    localparam int SIGN_BIT = 6;
    localparam int MAG_MSB  = 5;
    localparam int MAG_W    = 6;
    localparam int LVL_W    = 7;

    // Value of every pulse level register after reset.
    localparam logic [6:0] LEVEL_RST = 7'h00;

    // Time slot length: a quarter of a 488 ns bit cell.
    localparam int SLOT_TIME_NS  = 122;
    localparam int CLK_PERIOD_NS = 50;
    // Longest time, so rounded down, never below one cycle.
    localparam int SLOT_CYCLES   = (SLOT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (SLOT_TIME_NS / CLK_PERIOD_NS);

    // Number of time slots in one bit cell.
    localparam int NUM_SLOTS = 4;

    // Waveform generator states.
    typedef enum logic [0:0] {
        CLPS_IDLE = 1'b0,
        CLPS_RUN  = 1'b1
    } clps_state_t;

endpackage

// [core/clps_slot_reg.sv]
`timescale 1ns/10ps
`default_nettype none

// One pulse level register: a sign bit and a six bit magnitude.
module clps_slot_reg #(
    parameter logic [4:0] OFFSET = 5'h1C
) (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [2:0] reg_page,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [6:0] level_r
);

    // Next value of the stored sign and magnitude.
    logic [6:0] level_nxt;
    // High when this register is the target of the current write.
    logic       hit;

    // A write to this page and offset loads bits 6..0; bit 7 is dropped.
    always_comb begin
        hit       = wr_en && (reg_page == clps_pkg::PAGE_PULSE) && (reg_addr == OFFSET);
        level_nxt = level_r;
        if (hit) begin
            level_nxt = reg_wdata[6:0];
        end
    end

    // Storage, cleared to zero by reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_r <= clps_pkg::LEVEL_RST;
        end else begin
            level_r <= level_nxt;
        end
    end

    // A write lands in the register on the next edge.
    AST_WRITE_LOADS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hit |=> level_r == $past(reg_wdata[6:0]))
        else $error("Pulse level write was not stored.");

    // Without a write the register holds its value.
    AST_HOLD_NO_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !hit |=> $stable(level_r))
        else $error("Pulse level changed without a write.");

endmodule

`default_nettype wire

// [core/custom_line_pulse_shape.sv]
// Functional notes
// - Sign one gives positive level for a positive-going mark.
// - Sign zero gives negative slot level.
// - Slot one magnitude bits 5..0, reset zero.
// - Magnitude is unsigned, bit 5 most significant.
// - Slot two sign and magnitude, reset zero.
// - Slot three sign and magnitude, reset zero.
// - Slot four at offset 1F, reset zero.
`timescale 1ns/10ps
`default_nettype none

// Custom transmit pulse shape: four programmable levels played per bit cell.
module custom_line_pulse_shape #(
    parameter int SLOT_CYCLES = clps_pkg::SLOT_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] reg_page,
    input  wire logic [4:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_r,
    input  wire logic       cell_start,
    input  wire logic       cell_mark,
    input  wire logic       cell_negative,
    output logic      [6:0] line_level_r,
    output logic      [1:0] slot_index_r,
    output logic            shaping_active_r
);

    // The slot counter is eight bits wide, so longer slots cannot be served.
    if (SLOT_CYCLES < 1 || SLOT_CYCLES > 255) begin : g_bad_slot_cycles
        $error("SLOT_CYCLES must lie between 1 and 255.");
    end

    // Counter end value at the counter's own width.
    localparam logic [7:0] CNT_LAST = 8'(SLOT_CYCLES - 1);

    // Stored sign and magnitude of each slot, index 0 is the first slot.
    logic [6:0] slot_level [4];

    // Generator state and its next values.
    clps_pkg::clps_state_t state_r;
    clps_pkg::clps_state_t state_nxt;
    logic [7:0]            cnt_r;
    logic [7:0]            cnt_nxt;
    logic [1:0]            slot_nxt;
    logic                  mark_r;
    logic                  mark_nxt;
    logic                  neg_r;
    logic                  neg_nxt;
    logic [6:0]            level_nxt;
    logic                  active_nxt;
    // Read data next value.
    logic [7:0]            rdata_nxt;

    // Offsets of the four registers, in slot order.
    localparam logic [4:0] SLOT_OFS [4] = '{clps_pkg::OFS_SLOT_ONE, clps_pkg::OFS_SLOT_TWO,
                                            clps_pkg::OFS_SLOT_THREE, clps_pkg::OFS_SLOT_FOUR};

    // One register instance per time slot.
    for (genvar g = 0; g < clps_pkg::NUM_SLOTS; g++) begin : g_slot
        clps_slot_reg #(
            .OFFSET (SLOT_OFS[g])
        ) u_reg (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .wr_en     (reg_wr_en),
            .reg_page  (reg_page),
            .reg_addr  (reg_addr),
            .reg_wdata (reg_wdata),
            .level_r   (slot_level[g])
        );
    end

    // Turns a stored sign and magnitude into a signed line level.
    function automatic logic [6:0] shape_level(input logic [6:0] cfg, input logic neg);
        logic [6:0] mag;
        logic [6:0] lvl;
        // Unsigned magnitude, bit 5 is its most significant bit.
        mag = {1'b0, cfg[clps_pkg::MAG_MSB:0]};
        if (cfg[clps_pkg::SIGN_BIT]) begin
            lvl = mag;
        end else begin
            lvl = 7'(-mag);
        end
        // A negative going mark mirrors the whole shape.
        if (neg) begin
            lvl = 7'(-lvl);
        end
        return lvl;
    endfunction

    // Register read path: bit 7 and unmapped addresses read zero.
    always_comb begin
        rdata_nxt = reg_rdata_r;
        if (reg_rd_en) begin
            rdata_nxt = 8'h00;
            if (reg_page == clps_pkg::PAGE_PULSE) begin
                case (reg_addr)
                    clps_pkg::OFS_SLOT_ONE: begin
                        rdata_nxt = {1'b0, slot_level[0]};
                    end
                    clps_pkg::OFS_SLOT_TWO: begin
                        rdata_nxt = {1'b0, slot_level[1]};
                    end
                    clps_pkg::OFS_SLOT_THREE: begin
                        rdata_nxt = {1'b0, slot_level[2]};
                    end
                    clps_pkg::OFS_SLOT_FOUR: begin
                        rdata_nxt = {1'b0, slot_level[3]};
                    end
                    default: begin
                        rdata_nxt = 8'h00;
                    end
                endcase
            end
        end
    end

    // Read data register; holds the last answer until the next read.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // Slot sequencer: a new cell start always restarts at the first slot.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        slot_nxt  = slot_index_r;
        mark_nxt  = mark_r;
        neg_nxt   = neg_r;
        if (cell_start) begin
            // Latch the cell's polarity and begin slot one.
            state_nxt = clps_pkg::CLPS_RUN;
            cnt_nxt   = 8'h00;
            slot_nxt  = 2'h0;
            mark_nxt  = cell_mark;
            neg_nxt   = cell_negative;
        end else begin
            case (state_r)
                clps_pkg::CLPS_RUN: begin
                    if (cnt_r == CNT_LAST) begin
                        cnt_nxt = 8'h00;
                        if (slot_index_r == 2'h3) begin
                            // Fourth slot done: the cell is over.
                            state_nxt = clps_pkg::CLPS_IDLE;
                            slot_nxt  = 2'h0;
                        end else begin
                            slot_nxt = 2'(slot_index_r + 2'h1);
                        end
                    end else begin
                        cnt_nxt = 8'(cnt_r + 8'h01);
                    end
                end
                default: begin
                    cnt_nxt  = 8'h00;
                    slot_nxt = 2'h0;
                end
            endcase
        end
        // Space cells and idle time drive level zero.
        active_nxt = (state_nxt == clps_pkg::CLPS_RUN);
        level_nxt  = 7'h00;
        if (active_nxt && mark_nxt) begin
            level_nxt = shape_level(slot_level[slot_nxt], neg_nxt);
        end
    end

    // Sequencer and output registers.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r          <= clps_pkg::CLPS_IDLE;
            cnt_r            <= 8'h00;
            slot_index_r     <= 2'h0;
            mark_r           <= 1'b0;
            neg_r            <= 1'b0;
            line_level_r     <= 7'h00;
            shaping_active_r <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            cnt_r            <= cnt_nxt;
            slot_index_r     <= slot_nxt;
            mark_r           <= mark_nxt;
            neg_r            <= neg_nxt;
            line_level_r     <= level_nxt;
            shaping_active_r <= active_nxt;
        end
    end

    // A cell start of a positive-going mark, whatever the sign of the first slot.
    sequence s_pos_mark_start;
        cell_start && cell_mark && !cell_negative;
    endsequence

    // Sign one, positive mark: first slot shows the plain magnitude.
    AST_SIGN_POSITIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_pos_mark_start ##0 slot_level[0][6]
        |=> line_level_r == {1'b0, $past(slot_level[0][5:0])})
        else $error("Positive sign did not give a positive level.");

    // Sign zero, positive mark: first slot shows the negated magnitude.
    AST_SIGN_NEGATIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_pos_mark_start ##0 !slot_level[0][6]
        |=> line_level_r == 7'(-{1'b0, $past(slot_level[0][5:0])}))
        else $error("Zero sign did not give a negative level.");

    // The level never exceeds the six bit unsigned magnitude range.
    AST_MAG_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $signed(line_level_r) <= 7'sd63 && $signed(line_level_r) >= -7'sd63)
        else $error("Line level outside magnitude range.");

    // Each slot stands for SLOT_CYCLES cycles, then the next slot follows.
    AST_SLOT_ADVANCE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (shaping_active_r && cnt_r == CNT_LAST && slot_index_r != 2'h3 && !cell_start)
        |=> slot_index_r == 2'($past(slot_index_r) + 2'h1))
        else $error("Slot did not advance after its length.");

    // A space cell keeps the line at zero.
    AST_SPACE_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cell_start && !cell_mark) |=> line_level_r == 7'h00)
        else $error("Space cell drove a non-zero level.");

    // A read of slot four returns its value with bit 7 clear.
    AST_READ_SLOT_FOUR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd_en && reg_page == clps_pkg::PAGE_PULSE && reg_addr == clps_pkg::OFS_SLOT_FOUR)
        |=> reg_rdata_r == {1'b0, $past(slot_level[3])})
        else $error("Slot four read returned wrong data.");

    // Bit 7 of the read data is always zero.
    AST_BIT7_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !reg_rdata_r[7])
        else $error("Read data bit 7 was set.");

    // A write then read of slot one returns the written bits 6..0.
    sequence s_write_one;
        reg_wr_en && reg_page == clps_pkg::PAGE_PULSE && reg_addr == clps_pkg::OFS_SLOT_ONE;
    endsequence
    AST_WRITE_READBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_write_one ##1 (reg_rd_en && !reg_wr_en && reg_page == clps_pkg::PAGE_PULSE
                          && reg_addr == clps_pkg::OFS_SLOT_ONE)
        |=> reg_rdata_r == {1'b0, $past(reg_wdata[6:0], 2)})
        else $error("Slot one read back differs from write.");

endmodule

`default_nettype wire

// [bench/custom_line_pulse_shape_bench.sv]
`timescale 1ns/10ps
`default_nettype none

// Compares one observed value with its expected value and counts the result.
`define CLPS_CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t ns: got %h, expected %h", $time, act, exp); end end

// Self-checking bench: drivers queue expectations, a monitor pops and compares them.
module custom_line_pulse_shape_bench;
    localparam int SC = 2;                  // Cycles per time slot in this run.

    logic       ref_clk;                    // Line clock, 20 MHz.
    logic       sys_rst;                    // Asynchronous reset, active high.
    logic [2:0] reg_page;                   // Page select of the register bus.
    logic [4:0] reg_addr;                   // Offset within the page.
    logic       reg_wr_en;                  // Write strobe.
    logic       reg_rd_en;                  // Read strobe.
    logic [7:0] reg_wdata;                  // Write data.
    logic [7:0] reg_rdata_r;                // Registered read data.
    logic       cell_start;                 // Start of a bit cell.
    logic       cell_mark;                  // Mark or space for the cell.
    logic       cell_negative;              // Negative-going mark.
    logic [6:0] line_level_r;               // Level of the current slot.
    logic [1:0] slot_index_r;               // Current slot number.
    logic       shaping_active_r;           // High while a cell plays.
    logic [6:0] model [4];                  // Bench copy of the four level registers.
    logic [7:0] rd_q [$];                   // Expected read answers, oldest first.
    logic [9:0] wv_q [$];                   // Expected {active, slot, level} per cycle.
    logic [7:0] exp_b;                      // Read answer taken off the queue.
    logic [9:0] exp_w;                      // Waveform sample taken off the queue.
    logic       rd_d;                       // A read was taken at the last edge.
    logic       st_d;                       // A cell start was taken at the last edge.
    int         wl;                         // Waveform samples still to compare.
    int         n_fail;                     // Mismatches seen.
    int         total_checks;               // Comparisons made.
    int         seed;                       // Seed of the random stimulus.
    logic [31:0] r;                         // Random word for one access.

    custom_line_pulse_shape #(.SLOT_CYCLES(SC)) i_dut (
        .ref_clk         (ref_clk),
        .sys_rst         (sys_rst),
        .reg_page        (reg_page),
        .reg_addr        (reg_addr),
        .reg_wr_en       (reg_wr_en),
        .reg_rd_en       (reg_rd_en),
        .reg_wdata       (reg_wdata),
        .reg_rdata_r     (reg_rdata_r),
        .cell_start      (cell_start),
        .cell_mark       (cell_mark),
        .cell_negative   (cell_negative),
        .line_level_r    (line_level_r),
        .slot_index_r    (slot_index_r),
        .shaping_active_r(shaping_active_r)
    );

    // Free-running clock, 50 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Signed level of one register, mirrored for a negative mark, zero for space.
    function automatic logic [6:0] lvl_of(logic [6:0] v, logic mark, logic neg);
        logic [6:0] l;
        l = v[6] ? {1'b0, v[5:0]} : 7'h00 - {1'b0, v[5:0]};
        if (neg) begin
            l = 7'h00 - l;
        end
        return mark ? l : 7'h00;
    endfunction

    // Drives one register cycle and leaves the strobes standing for a following call.
    // A read queues the value held before any same-cycle write.
    task automatic put(input logic wr, input logic rd, input logic [2:0] pg,
                       input logic [4:0] ad, input logic [7:0] d);
        logic hit;
        hit = (pg === clps_pkg::PAGE_PULSE) && (ad[4:2] === 3'h7);
        @(posedge ref_clk);
        reg_wr_en <= wr;
        reg_rd_en <= rd;
        reg_page  <= pg;
        reg_addr  <= ad;
        reg_wdata <= d;
        if (rd) begin
            rd_q.push_back(hit ? {1'b0, model[ad[1:0]]} : 8'h00);
        end
        if (wr && hit) begin
            model[ad[1:0]] = d[6:0];
        end
    endtask

    // One register cycle followed by a released bus.
    task automatic acc(input logic wr, input logic rd, input logic [2:0] pg,
                       input logic [4:0] ad, input logic [7:0] d);
        put(wr, rd, pg, ad, d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
    endtask

    // Plays one bit cell and queues the expected level of every cycle.
    task automatic play_cell(input logic mark, input logic neg);
        @(posedge ref_clk);
        cell_start    <= 1'b1;
        cell_mark     <= mark;
        cell_negative <= neg;
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < SC; c++) begin
                wv_q.push_back({1'b1, 2'(k), lvl_of(model[k], mark, neg)});
            end
        end
        wv_q.push_back(10'h000);
        @(posedge ref_clk);
        cell_start    <= 1'b0;
        cell_mark     <= ~mark;
        cell_negative <= ~neg;
        repeat (4 * SC) @(posedge ref_clk);
    endtask

    // Reads all four level registers back.
    task automatic read_all();
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 1'b1, clps_pkg::PAGE_PULSE, clps_pkg::OFS_SLOT_ONE + 5'(i), 8'h00);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (rd_q.size() != 0 || wv_q.size() != 0) begin
            n_fail++;
            $display("[FAIL] %0t ns: expected results never appeared", $time);
        end
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Notes at each edge whether a read or a cell start was taken.
    always @(posedge ref_clk) begin
        rd_d <= reg_rd_en && !sys_rst;
        st_d <= cell_start && !sys_rst;
    end

    // Compares settled outputs with the oldest expectations.
    always @(negedge ref_clk) begin
        if (rd_d) begin
            exp_b = rd_q.pop_front();
            `CLPS_CHK(reg_rdata_r, exp_b)
        end
        if (st_d) begin
            wl = 4 * SC + 1;
        end
        if (wl > 0) begin
            exp_w = wv_q.pop_front();
            `CLPS_CHK({shaping_active_r, slot_index_r, line_level_r}, exp_w)
            wl--;
        end
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        $display("[FAIL] %0t ns: run did not finish", $time);
        complete_run();
    end

    // Main sequence.
    initial begin
        seed = 32'hBA20890A;
        {sys_rst, reg_page, reg_addr, reg_wr_en, reg_rd_en, reg_wdata} = 19'h40000;
        {cell_start, cell_mark, cell_negative} = 3'h0;
        {n_fail, total_checks, wl} = '0;
        for (int i = 0; i < 4; i++) model[i] = 7'h00;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        read_all();
        // Every sign, the largest magnitude and a set bit 7.
        acc(1'b1, 1'b0, 3'h2, 5'h1C, 8'hC5);
        acc(1'b1, 1'b0, 3'h2, 5'h1D, 8'h3F);
        acc(1'b1, 1'b0, 3'h2, 5'h1E, 8'h60);
        acc(1'b1, 1'b0, 3'h2, 5'h1F, 8'hFF);
        read_all();
        play_cell(1'b1, 1'b0);
        play_cell(1'b1, 1'b1);
        play_cell(1'b0, 1'b0);
        // Same-cycle read and write, then refused pages and offsets.
        acc(1'b1, 1'b1, 3'h2, 5'h1C, 8'h01);
        acc(1'b1, 1'b1, 3'h2, 5'h1B, 8'hFF);
        acc(1'b1, 1'b1, 3'h3, 5'h1F, 8'h7F);
        acc(1'b1, 1'b0, 3'h1, 5'h1D, 8'h55);
        // A write to slot one and, in the very next cycle, a read of it.
        put(1'b1, 1'b0, 3'h2, 5'h1C, 8'hA7);
        acc(1'b0, 1'b1, 3'h2, 5'h1C, 8'h00);
        read_all();
        repeat (80) begin
            r = $random(seed);
            acc(r[9], r[10], r[0] ? 3'h2 : r[3:1], r[1] ? {3'h7, r[5:4]} : r[8:4], r[18:11]);
            if (r[20:19] == 2'h0) begin
                play_cell(r[21], r[22]);
            end
        end
        read_all();
        // A second reset in mid-run clears all four registers.
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) model[i] = 7'h00;
        read_all();
        play_cell(1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        complete_run();
    end
endmodule

`default_nettype wire
